// File: smr_defs.svh
// Purpose: offsets, reset values, codes and counts for smr block
// Assumes: mode-register addresses are the six-bit MA field
// Notes:   addresses, reset values and codes of the block live here; bit positions are written in the code
`ifndef SMR_DEFS_SVH
`define SMR_DEFS_SVH
// ==========================================================
// register addresses
`define SMR_ADDR_BANK_MASK    6'h10
`define SMR_ADDR_SEG_MASK     6'h11
`define SMR_ADDR_CNT_LOW      6'h12
`define SMR_ADDR_CNT_HIGH     6'h13
`define SMR_ADDR_UB_INVERT    6'h14
`define SMR_ADDR_RSVD_A       6'h15
`define SMR_ADDR_TERM         6'h16
`define SMR_ADDR_RUNTIME      6'h17
`define SMR_ADDR_ROW_HAMMER   6'h18
// ==========================================================
// reset values
`define SMR_RST_BANK_MASK     8'h00
`define SMR_RST_SEG_MASK      8'h00
`define SMR_RST_UB_INVERT     8'h55
`define SMR_RST_TERM          8'h00
`define SMR_RST_RUNTIME       8'h00
`define SMR_RST_RH_CTRL       4'h0
// ==========================================================
// fields and codes
`define SMR_TERM_CODE_RSVD    3'h7
`define SMR_MPC_STOP_OSC      7'h4D
`define SMR_RT_SHORT_UNIT     16
`define SMR_RT_2048           16'h0800
`define SMR_RT_4096           16'h1000
`define SMR_RT_8192           16'h2000
`define SMR_MAC_RSVD          3'h7
`define SMR_MAC_NONE          3'h0
`endif

// File: smr_pkg.sv
// Purpose: shared types of the smr block
// Assumes: nothing beyond the defs header
// Notes:   types only
package smr_pkg;
  // ========================================================
  // termination setting as applied to the pads
  typedef struct packed {
    logic       ca_term_dis;
    logic       cs_term_dis;
    logic       ck_term_dis;
    logic [2:0] ctrl_term_code;
  } smr_term_s;
  // ========================================================
  // mode-register command from the command decoder
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] data;
  } smr_cmd_s;
  typedef enum logic [0:0] {SMR_TMR_IDLE, SMR_TMR_RUN} smr_tmr_e;
endpackage

// File: smr_regs.sv
// Purpose: mode-register bank for refresh masks, training count,
//          pattern invert, termination, strobe timer and row hammer
// Assumes: decoded mode-register commands arrive one cycle wide
// Notes:   read data valid one cycle after rd
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_regs (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  // mode-register command
  input  wire smr_pkg::smr_cmd_s cmd,
  input  wire logic             chan_sel,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  // setpoint selects and io configuration
  input  wire logic             setpoint_write_select,
  input  wire logic             setpoint_operate_select,
  input  wire logic             io_dbi_rd_en,
  // strobe oscillator
  input  wire logic             osc_start,
  input  wire logic             osc_stop,
  input  wire logic             osc_tick,
  output logic                  osc_running,
  // fixed device facts
  input  wire logic [2:0]       mac_value_in,
  input  wire logic             mac_unlimited_in,
  // refresh and pad controls
  output logic [7:0]            bank_mask_ch0,
  output logic [7:0]            bank_mask_ch1,
  output logic [7:0]            seg_mask_ch0,
  output logic [7:0]            seg_mask_ch1,
  output smr_pkg::smr_term_s    term_active,
  output logic [7:0]            dq_invert_upper,
  output logic                  upper_data_mask_lane_inv,
  output logic                  cal_dbi_en,
  output logic                  trr_en,
  output logic [2:0]            trr_bank
);
  // ========================================================
  // functions
  function automatic logic [15:0] runtime_limit(input logic [7:0] rt);
    logic [15:0] lim;
    lim = 16'h0000;
    case (rt[7:6])
      2'b01:   lim = `SMR_RT_2048;
      2'b10:   lim = `SMR_RT_4096;
      2'b11:   lim = `SMR_RT_8192;
      default: lim = 16'({rt[5:0]} * `SMR_RT_SHORT_UNIT);
    endcase
    return lim;
  endfunction
  function automatic logic [2:0] mac_field(input logic [2:0] v,
                                          input logic unl);
    logic [2:0] f;
    f = (unl || v == `SMR_MAC_RSVD) ? `SMR_MAC_NONE : v;
    return f;
  endfunction

  // ========================================================
  // register state
  logic [7:0]  bank_r [2];
  logic [7:0]  seg_r  [2];
  logic [7:0]  bank_nxt [2];
  logic [7:0]  seg_nxt  [2];
  logic [7:0]  inv_r, inv_nxt;
  logic [5:0]  term_r [2];
  logic [5:0]  term_nxt [2];
  logic [7:0]  rt_r, rt_nxt;
  logic [3:0]  rh_r, rh_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  smr_pkg::smr_tmr_e st_r, st_nxt;
  logic [7:0]  rd_nxt;
  logic        ch;
  logic        fw;

  assign ch = chan_sel;
  assign fw = setpoint_write_select;

  always_comb begin
    bank_nxt = bank_r;
    seg_nxt  = seg_r;
    inv_nxt  = inv_r;
    term_nxt = term_r;
    rt_nxt   = rt_r;
    rh_nxt   = rh_r;
    if (cmd.wr) begin
      case (cmd.addr)
        `SMR_ADDR_BANK_MASK:  bank_nxt[ch] = cmd.data;
        `SMR_ADDR_SEG_MASK:   seg_nxt[ch]  = cmd.data;
        `SMR_ADDR_UB_INVERT:  inv_nxt      = cmd.data;
        `SMR_ADDR_TERM:       term_nxt[fw] = cmd.data[5:0];
        `SMR_ADDR_RUNTIME:    rt_nxt       = cmd.data;
        `SMR_ADDR_ROW_HAMMER: rh_nxt       = cmd.data[7:4];
        default: ;
      endcase
    end
  end

  // ========================================================
  // oscillator count and interval timer
  always_comb begin
    cnt_nxt = cnt_r;
    tmr_nxt = tmr_r;
    st_nxt  = st_r;
    case (st_r)
      smr_pkg::SMR_TMR_IDLE: begin
        if (osc_start) begin
          cnt_nxt = 16'h0000;
          tmr_nxt = 16'h0000;
          st_nxt  = smr_pkg::SMR_TMR_RUN;
        end
      end
      smr_pkg::SMR_TMR_RUN: begin
        if (osc_start) begin
          cnt_nxt = 16'h0000;
          tmr_nxt = 16'h0000;
        end else begin
          tmr_nxt = tmr_r + 16'h0001;
          if (osc_tick)
            cnt_nxt = cnt_r + 16'h0001;
          if (rt_r == 8'h00) begin
            if (osc_stop)
              st_nxt = smr_pkg::SMR_TMR_IDLE;
          end else if (tmr_nxt >= runtime_limit(rt_r)) begin
            st_nxt = smr_pkg::SMR_TMR_IDLE;
          end
        end
      end
      default: st_nxt = smr_pkg::SMR_TMR_IDLE;
    endcase
  end

  // ========================================================
  // read path
  always_comb begin
    rd_nxt = 8'h00;
    case (cmd.addr)
      `SMR_ADDR_CNT_LOW:   rd_nxt = cnt_r[7:0];
      `SMR_ADDR_CNT_HIGH:  rd_nxt = cnt_r[15:8];
      `SMR_ADDR_TERM:      rd_nxt = {2'b00, term_r[fw]};
      `SMR_ADDR_ROW_HAMMER:
        rd_nxt = {rh_r, mac_unlimited_in,
                  mac_field(mac_value_in, mac_unlimited_in)};
      default:             rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_r   <= '{`SMR_RST_BANK_MASK, `SMR_RST_BANK_MASK};
      seg_r    <= '{`SMR_RST_SEG_MASK, `SMR_RST_SEG_MASK};
      inv_r    <= `SMR_RST_UB_INVERT;
      term_r   <= '{6'(`SMR_RST_TERM), 6'(`SMR_RST_TERM)};
      rt_r     <= `SMR_RST_RUNTIME;
      rh_r     <= `SMR_RST_RH_CTRL;
      cnt_r    <= 16'h0000;
      tmr_r    <= 16'h0000;
      st_r     <= smr_pkg::SMR_TMR_IDLE;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      bank_r   <= bank_nxt;
      seg_r    <= seg_nxt;
      inv_r    <= inv_nxt;
      term_r   <= term_nxt;
      rt_r     <= rt_nxt;
      rh_r     <= rh_nxt;
      cnt_r    <= cnt_nxt;
      tmr_r    <= tmr_nxt;
      st_r     <= st_nxt;
      rd_data  <= cmd.rd ? rd_nxt : 8'h00;
      rd_valid <= cmd.rd;
    end
  end

  // ========================================================
  // outputs, each from a flip-flop
  logic [5:0] term_op;
  assign term_op = term_r[setpoint_operate_select];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_mask_ch0   <= `SMR_RST_BANK_MASK;
      bank_mask_ch1   <= `SMR_RST_BANK_MASK;
      seg_mask_ch0    <= `SMR_RST_SEG_MASK;
      seg_mask_ch1    <= `SMR_RST_SEG_MASK;
      term_active     <= '0;
      dq_invert_upper <= `SMR_RST_UB_INVERT;
      upper_data_mask_lane_inv <= 1'b0;
      cal_dbi_en      <= 1'b0;
      trr_en          <= 1'b0;
      trr_bank        <= 3'h0;
      osc_running     <= 1'b0;
    end else if (clk_en) begin
      bank_mask_ch0   <= bank_r[0];
      bank_mask_ch1   <= bank_r[1];
      seg_mask_ch0    <= seg_r[0];
      seg_mask_ch1    <= seg_r[1];
      // reserved code falls back to off rather than an unknown drive
      term_active.ctrl_term_code <= (term_op[2:0] == `SMR_TERM_CODE_RSVD)
                                    ? 3'h0 : term_op[2:0];
      term_active.ck_term_dis <= term_op[3];
      term_active.cs_term_dis <= term_op[4];
      term_active.ca_term_dis <= term_op[5];
      dq_invert_upper <= inv_r;
      upper_data_mask_lane_inv <= 1'b0;
      cal_dbi_en      <= 1'b0 & io_dbi_rd_en;
      trr_en          <= rh_r[3];
      trr_bank        <= rh_r[2:0];
      osc_running     <= (st_nxt == smr_pkg::SMR_TMR_RUN);
    end
  end

  // ========================================================
  // checks
  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && osc_start |=> cnt_r == 16'h0000)
    else $error("count not cleared on start");
  cnt_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && cmd.rd && cmd.addr == `SMR_ADDR_CNT_HIGH
      |=> rd_data == $past(cnt_r[15:8]))
    else $error("count high byte mismatch");
  bank_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && cmd.wr && cmd.addr == `SMR_ADDR_BANK_MASK && !chan_sel
      ##1 clk_en |=> bank_mask_ch0 == $past(cmd.data, 2))
    else $error("bank mask ch0 not applied");
  seg_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && cmd.wr && cmd.addr == `SMR_ADDR_SEG_MASK && chan_sel
      ##1 clk_en |=> seg_mask_ch1 == $past(cmd.data, 2))
    else $error("segment mask ch1 not applied");
  dm_true_a: assert property (@(posedge sys_clk) disable iff (srst)
    !upper_data_mask_lane_inv && !cal_dbi_en)
    else $error("mask lane inverted or dbi on");
  term_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && cmd.rd && cmd.addr == `SMR_ADDR_TERM
      |=> rd_data[5:0] == $past(term_r[fw]))
    else $error("termination read wrong copy");
  mac_unl_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && cmd.rd && cmd.addr == `SMR_ADDR_ROW_HAMMER
      && mac_unlimited_in |=> rd_data[3:0] == 4'h8)
    else $error("unlimited flag field not zero");
  tmr_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && st_r == smr_pkg::SMR_TMR_RUN && !osc_start
      && rt_r == 8'h01 && tmr_r == 16'h000F
      |=> st_r == smr_pkg::SMR_TMR_IDLE)
    else $error("timer did not stop at 16");
  man_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en && st_r == smr_pkg::SMR_TMR_RUN && rt_r == 8'h00
      && osc_stop && !osc_start |=> st_r == smr_pkg::SMR_TMR_IDLE)
    else $error("stop command ignored");
  trr_def_a: assert property (@(posedge sys_clk)
    srst ##1 !srst |-> !trr_en)
    else $error("row refresh enabled after reset");
  term_op_a: assert property (@(posedge sys_clk) disable iff (srst)
    clk_en ##1 clk_en |-> term_active.ck_term_dis
      == $past(term_r[setpoint_operate_select][3]))
    else $error("wrong operating setpoint");
endmodule

// File: smr_ctrl_model.sv
// Purpose: controller model issuing mode-register and oscillator commands
// Assumes: io config bit 0 is 1; drives 1 ns after the rising edge
// Notes:   released command lines show the inverse of the last value
`timescale 1ns/1ps
`include "smr_defs.svh"
module smr_ctrl_model (
  // clock and density strap
  input  wire logic        sys_clk,
  input  wire logic        small_dens,
  // command side
  output smr_pkg::smr_cmd_s cmd,
  output logic             chan_sel,
  output logic             osc_start,
  output logic             osc_stop,
  // read return
  input  wire logic [7:0]  rd_data,
  input  wire logic        rd_valid
);
  localparam bit IO_CFG_B0 = 1'b1;
  logic [7:0] runtime_r = 8'h00;
  initial begin
    {cmd, chan_sel, osc_start, osc_stop} = '0;
  end
  // ========================================================
  // mode-register access
  task automatic mode_reg_write(input logic [5:0] a, input logic [7:0] d,
                     input logic ch);
    @(posedge sys_clk) #1;
    if (a == `SMR_ADDR_SEG_MASK && small_dens) d[7:6] = 2'b00;
    if (a == `SMR_ADDR_TERM && !IO_CFG_B0
        && d[2:0] inside {3'h1, 3'h3, 3'h5, 3'h6})
      d[2:0] = 3'h0;
    if (a == `SMR_ADDR_RUNTIME) runtime_r = d;
    cmd = '{1'b1, 1'b0, a, d};
    chan_sel = ch;
    @(posedge sys_clk) #1;
    cmd = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic mode_reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1;
    cmd = '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) #1;
    cmd = '{1'b0, 1'b0, ~a, 8'hFF};
    for (int i = 0; i < 3 && rd_valid !== 1'b1; i++) @(posedge sys_clk) #1;
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
  // both bytes joined into one count
  task automatic rd_count(output logic [15:0] c);
    mode_reg_read(`SMR_ADDR_CNT_HIGH, c[15:8]);
    mode_reg_read(`SMR_ADDR_CNT_LOW, c[7:0]);
  endtask
  task automatic osc(input bit stop);
    @(posedge sys_clk) #1;
    if (stop) osc_stop = (runtime_r == 8'h00);
    else osc_start = 1'b1;
    @(posedge sys_clk) #1;
    {osc_start, osc_stop} = 2'b00;
  endtask
endmodule

// File: sdram_mode_regs_partial_array_self_refresh_train_odt_tb.sv
// Purpose: self-checking bench for the smr mode-register bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   expectations come from a plain model held in arrays
`timescale 1ns/1ps
`include "smr_defs.svh"
module sdram_mode_regs_partial_array_self_refresh_train_odt_tb;
  logic sys_clk, srst, clk_en, setpoint_write_select, setpoint_operate_select;
  logic io_dbi_rd_en, osc_tick, mac_unlimited_in, small_dens, rd_valid;
  logic chan_sel, osc_start, osc_stop, osc_running, trr_en, cal_dbi_en;
  logic upper_data_mask_lane_inv;
  logic [2:0] mac_value_in, trr_bank;
  logic [7:0] rd_data, bank_mask_ch0, bank_mask_ch1, seg_mask_ch0;
  logic [7:0] seg_mask_ch1, dq_invert_upper, d, bm[2], sm[2], tm[2];
  logic [15:0] c;
  logic [31:0] rnd = 32'hC933;
  smr_pkg::smr_cmd_s cmd;
  smr_pkg::smr_term_s term_active;
  int error_cnt = 0, tests_run = 0, n;
  logic [7:0] rts[6] = '{8'h01, 8'h3F, 8'h40, 8'h80, 8'hC0, 8'h00};
  int lim[6] = '{16, 1008, 2048, 4096, 8192, 40};
  logic [5:0] adr[4] = '{6'h12, 6'h15, 6'h3F, 6'h10};
  smr_regs smr_regs_inst (.sys_clk, .srst, .clk_en, .cmd, .chan_sel,
    .rd_data, .rd_valid, .setpoint_write_select, .setpoint_operate_select,
    .io_dbi_rd_en, .osc_start, .osc_stop, .osc_tick, .osc_running,
    .mac_value_in, .mac_unlimited_in, .bank_mask_ch0, .bank_mask_ch1,
    .seg_mask_ch0, .seg_mask_ch1, .term_active, .dq_invert_upper,
    .upper_data_mask_lane_inv, .cal_dbi_en, .trr_en, .trr_bank);
  smr_ctrl_model smr_ctrl_model_inst (.sys_clk, .small_dens, .cmd,
    .chan_sel, .osc_start, .osc_stop, .rd_data, .rd_valid);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [5:0] texp(input logic [7:0] v);
    return {v[5:3], (v[2:0] == 3'h7) ? 3'h0 : v[2:0]};
  endfunction
  task automatic cmp(input string k, input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s at %0t: %h not %h", k, $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [15:0] g, e);
    cmp("read", {16'h0, g}, {16'h0, e});
  endtask
  task automatic chk_pin(input logic [31:0] g, e);
    cmp("pin", g, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  // ========================================================
  // tests
  initial begin
    {srst, clk_en, setpoint_write_select, setpoint_operate_select} = 4'hC;
    {io_dbi_rd_en, osc_tick, mac_unlimited_in, small_dens} = 4'h0;
    mac_value_in = 3'h0;
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    chk_pin({bank_mask_ch0, bank_mask_ch1, seg_mask_ch0, seg_mask_ch1}, 0);
    chk_pin({dq_invert_upper, trr_en, term_active},
            {17'h00000, 8'h55, 1'b0, 6'h00});
    for (int j = 0; j < 4; j++) begin
      if (j < 3) smr_ctrl_model_inst.mode_reg_write(adr[j], 8'hFF, 1'b0);
      smr_ctrl_model_inst.mode_reg_read(adr[j], d);
      chk_rd(d, 16'h0);
    end
    $display("done: reset and refused");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      small_dens = rnd[8];
      smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_BANK_MASK, rnd[7:0], 1'b0);
      smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_BANK_MASK, rnd[15:8], 1'b1);
      smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_SEG_MASK, rnd[23:16], i[0]);
      bm = '{rnd[7:0], rnd[15:8]};
      sm[i[0]] = rnd[23:16] & (small_dens ? 8'h3F : 8'hFF);
      if (i == 0) sm[1] = 8'h00;
      @(posedge sys_clk) #1;
      chk_pin({bank_mask_ch0, bank_mask_ch1, seg_mask_ch0, seg_mask_ch1},
              {bm[0], bm[1], sm[0], sm[1]});
    end
    clk_en = 1'b0;
    smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_BANK_MASK, ~bm[0], 1'b0);
    clk_en = 1'b1;
    repeat (2) @(posedge sys_clk) #1;
    chk_pin(bank_mask_ch0, bm[0]);
    io_dbi_rd_en = 1'b1;
    smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_UB_INVERT, rnd[31:24], 1'b0);
    @(posedge sys_clk) #1;
    chk_pin({dq_invert_upper, upper_data_mask_lane_inv, cal_dbi_en},
            {rnd[31:24], 2'b00});
    $display("done: masks and invert");
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      setpoint_write_select = k[0];
      tm[k[0]] = {2'b00, rnd[5:3], k[3:1]};
      smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_TERM, {rnd[7:6], tm[k[0]][5:0]},
                              1'b0);
      for (int s = 0; s < 2 && k[0]; s++) begin
        setpoint_operate_select = s[0];
        repeat (2) @(posedge sys_clk) #1;
        chk_pin(term_active, texp(tm[s]));
      end
    end
    $display("done: termination");
    smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_ROW_HAMMER, rnd[15:8], 1'b0);
    for (int m = 0; m < 16; m++) begin
      {mac_unlimited_in, mac_value_in} = m[3:0];
      smr_ctrl_model_inst.mode_reg_read(`SMR_ADDR_ROW_HAMMER, d);
      chk_rd(d, {rnd[15:12], m[3], (m[3] || m[2:0] == 3'h7) ? 3'h0
             : m[2:0]});
    end
    chk_pin({trr_en, trr_bank}, rnd[15:12]);
    $display("done: row hammer");
    for (int t = 0; t < 6; t++) begin
      smr_ctrl_model_inst.mode_reg_write(`SMR_ADDR_RUNTIME, rts[t], 1'b0);
      smr_ctrl_model_inst.osc(1'b0);
      n = 0;
      osc_tick = 1'b1;
      while (osc_running === 1'b1 && n < 9000) begin
        @(posedge sys_clk) #1;
        n++;
        osc_tick = (n < 10);
        if (rts[t] == 8'h00 && n == 40) smr_ctrl_model_inst.osc(1'b1);
      end
      chk_pin(n, lim[t]);
      smr_ctrl_model_inst.rd_count(c);
      chk_rd(c, 16'd10);
    end
    $display("done: strobe timer");
    give_verdict();
  end
endmodule
